// ### sensor_scratchpad_status_regs_test.sv
`timescale 1ns/1ps
module sensor_scratchpad_status_regs_test;
  import sssr_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  sssr_req_s req;
  sssr_rsp_s rsp;
  logic conv_done = 1'b0, bus_reset = 1'b0, disc_addr_sent = 1'b0, cfg_lock_set = 1'b0, copy_req = 1'b0;
  logic pin_sample = 1'b0, pin_setup_wr = 1'b0, supply_bus_powered = 1'b0, ee_store, gp_o, gp_oe;
  logic [15:0] conv_result = 16'h0000;
  logic [7:0] pin_setup_data = 8'h00;
  logic [7:0] pin_level_snapshot;
  logic [3:0] pin_levels = 4'h0;
  sssr_cfg_s cfg, ee_store_image;
  sssr_cfg_s ee_image = '0;
  int errors = 0, num_checks = 0, seed = 82195, i;
  logic [7:0] mem [16];
  logic [7:0] rv;
  logic [3:0] a;
  logic ok, pwr;
  logic [15:0] corner [6] = '{16'h0100, 16'h00ff, 16'hff00, 16'hff01, 16'h8000, 16'h7fff};

  initial forever #20 sys_clk = ~sys_clk;

  sssr_host_model host (.sys_clk(sys_clk), .req(req), .rsp(rsp));

  sssr_regs uut (.sys_clk(sys_clk), .reset(reset), .req(req), .rsp(rsp), .conv_done(conv_done),
    .conv_result(conv_result), .cfg(cfg), .bus_reset(bus_reset), .disc_addr_sent(disc_addr_sent),
    .cfg_lock_set(cfg_lock_set), .copy_req(copy_req), .ee_image(ee_image), .ee_store(ee_store),
    .ee_store_image(ee_store_image), .supply_bus_powered(supply_bus_powered), .pin_levels(pin_levels),
    .pin_sample(pin_sample), .pin_setup_wr(pin_setup_wr), .pin_setup_data(pin_setup_data),
    .pin_level_snapshot(pin_level_snapshot), .second_general_pin_o(gp_o), .second_general_pin_oe(gp_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      errors++;
    end
  endtask

  task automatic rdchk(input logic [3:0] ad, input logic [7:0] exp);
    host.rd(ad, rv, ok);
    check({15'h0000, ok}, 16'h0001, "read answer");
    check({8'h00, rv}, {8'h00, exp}, $sformatf("byte %h", ad));
  endtask

  // one-cycle pulse on one of the event inputs; all are lowered together afterwards
  task automatic pulse(input int k);
    @(posedge sys_clk);
    #1;
    case (k)
      0: conv_done = 1'b1;
      1: bus_reset = 1'b1;
      2: disc_addr_sent = 1'b1;
      3: cfg_lock_set = 1'b1;
      4: copy_req = 1'b1;
      5: pin_sample = 1'b1;
      default: pin_setup_wr = 1'b1;
    endcase
    @(posedge sys_clk);
    #1 {conv_done, bus_reset, disc_addr_sent, cfg_lock_set, copy_req, pin_sample, pin_setup_wr} = '0;
  endtask

  task automatic conv(input logic [15:0] v);
    conv_result = v;
    pulse(0);
  endtask

  task automatic wrm(input logic [3:0] ad, input logic [7:0] d);
    host.wr(ad, d);
    if (isrw(ad))
      mem[ad] = d;
  endtask

  function automatic logic isrw(input logic [3:0] ad);
    return (ad >= 4'h4 && ad <= 4'h6) || (ad >= 4'h8 && ad <= 4'hd);
  endfunction

  function automatic logic [7:0] stat(input int h, l, f, d, k);
    return {1'(h), 1'(l), SSSR_FLAG_SPARE_BITS, 1'(f), pwr, 1'(d), 1'(k)};
  endfunction

  // limits used below: lower ff00h (-256), upper 0100h, compared as signed
  function automatic logic [7:0] cmp(input logic [15:0] v);
    return stat(int'($signed(v) >= $signed(16'h0100)), int'($signed(v) <= $signed(16'hff00)), 1, 0, 0);
  endfunction

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #800000;
    errors++;
    final_report();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    pwr = 1'($random(seed));
    supply_bus_powered = pwr;
    ee_image = '{8'($random(seed)), 8'($random(seed)) & 8'hf3, 8'($random(seed)),
                 16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    repeat (12) @(posedge sys_clk);
    #1;
    check({cfg.setup_one, cfg.setup_two}, 16'h7080, "setup reset");
    check(cfg.hi_lim, 16'h07f0, "upper limit reset");
    check({cfg.bus_id, pin_level_snapshot}, 16'h00f0, "id and snapshot reset");
    reset = 1'b0;
    repeat (2) @(posedge sys_clk);
    // expected image after the boot reload
    mem = '{8'h00, 8'h00, 8'h00, 8'hff, ee_image.setup_one, ee_image.setup_two, ee_image.bus_id, 8'hff,
            ee_image.lo_lim[7:0], ee_image.lo_lim[15:8], ee_image.hi_lim[7:0], ee_image.hi_lim[15:8],
            ee_image.cor[7:0], ee_image.cor[15:8], 8'hff, 8'hff};
    for (i = 0; i < 16; i++)
      rdchk(4'(i), (i == 2) ? stat(0, 0, 0, 0, 0) : mem[i]);
    // random writes everywhere, read-only and spare places included
    for (i = 0; i < 24; i++)
      wrm(4'($random(seed)), 8'($random(seed)));
    for (i = 0; i < 16; i++)
      if (i != 2)
        rdchk(4'(i), mem[i]);
    // comparator mode with fixed limits, corners first
    wrm(4'h4, mem[4] | 8'h10);
    wrm(4'h5, mem[5] & 8'hf3);
    wrm(4'h8, 8'h00);
    wrm(4'h9, 8'hff);
    wrm(4'ha, 8'h00);
    wrm(4'hb, 8'h01);
    for (i = 0; i < 14; i++)
    begin
      mem[0] = 8'($random(seed));
      mem[1] = 8'($random(seed));
      if (i < 6)
        {mem[1], mem[0]} = corner[i];
      conv({mem[1], mem[0]});
      rdchk(4'h0, mem[0]);
      rdchk(4'h1, mem[1]);
      rdchk(4'h2, cmp({mem[1], mem[0]}));
      rdchk(4'h2, stat(0, 0, 0, 0, 0));
    end
    // latched mode: a later in-range result does not clear the flag
    wrm(4'h4, mem[4] & 8'hef);
    conv(16'h0200);
    conv(16'h0000);
    rdchk(4'h2, stat(1, 0, 1, 0, 0));
    rdchk(4'h2, stat(0, 0, 0, 0, 0));
    // alert function on the second general pin
    pin_setup_data = 8'h04;
    pulse(6);
    conv(16'h0200);
    @(posedge sys_clk);
    #1 check({14'h0000, gp_oe, gp_o}, 16'h0002, "pin pulled low");
    // status read in the same cycle as a new conversion
    fork
      host.rd(4'h2, rv, ok);
      conv(16'h0000);
    join
    check({8'h00, rv}, {8'h00, stat(1, 0, 1, 0, 0)}, "status before clear");
    rdchk(4'h2, stat(0, 0, 1, 0, 0));
    check({15'h0000, gp_oe}, 16'h0000, "pin released");
    // supply source follows the pin at a bus reset
    pwr = ~pwr;
    supply_bus_powered = pwr;
    repeat (4) @(posedge sys_clk);
    pulse(1);
    rdchk(4'h2, stat(0, 0, 0, 0, 0));
    // discovery flag: sticky across reads, cleared by a zero select
    wrm(4'h5, mem[5] | 8'h04);
    pulse(2);
    rdchk(4'h2, stat(0, 0, 0, 1, 0));
    rdchk(4'h2, stat(0, 0, 0, 1, 0));
    wrm(4'h5, mem[5] & 8'hf3);
    rdchk(4'h2, stat(0, 0, 0, 0, 0));
    // copy command hands the current settings to the memory
    pulse(4);
    check({15'h0000, ee_store}, 16'h0001, "store pulse");
    check({ee_store_image.setup_one, ee_store_image.bus_id}, {mem[4], mem[6]}, "stored image");
    check(ee_store_image.hi_lim, {mem[11], mem[10]}, "stored limit");
    // lock rejects configuration writes
    pulse(3);
    rdchk(4'h2, stat(0, 0, 0, 0, 1));
    host.wr(4'h4, ~mem[4]);
    host.wr(4'hc, ~mem[12]);
    rdchk(4'h4, mem[4]);
    rdchk(4'hc, mem[12]);
    // pin snapshot after synchronisation
    pin_levels = 4'($random(seed));
    repeat (3) @(posedge sys_clk);
    pulse(5);
    check({8'h00, pin_level_snapshot}, {8'h00, SSSR_PIN_UPPER_ONES, pin_levels}, "pin snapshot");
    final_report();
  end

endmodule

// ### sssr_host_model.sv
`timescale 1ns/1ps
// host side of the scratchpad port, one strobe at a time, driven just after the clock edge
module sssr_host_model
  import sssr_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // scratchpad port
  output sssr_req_s req,
  input wire sssr_rsp_s rsp
);

  initial req = '0;

  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  // write: the strobe stands for exactly one taking edge; address and data are scrambled when idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read: the answer stands for one cycle right after the taking edge, so take it then
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk);
    #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    #1 req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    ok = rsp.valid;
    d = rsp.data;
  endtask

endmodule

// ### sssr_pkg.sv
// How it works
// R1: the latest 16-bit conversion output is held read-only, low byte at offset 00h and high byte at 01h.
// R2: both result bytes read 00h after power-up until the first conversion has finished.
// R3: both alert flags are re-evaluated whenever a new conversion result arrives.
// R4: a host read of the status byte clears both alert flags.
// R5: in latched alert mode a set alert flag stays set until a status read, whatever later results show.
// R6: status bit 7 is 1 when the last result is at or above the upper limit, else 0.
// R7: status bit 6 is 1 when the last result is at or below the lower limit, else 0.
// R8: with the second general pin set to its alert function, the pin shows the alert flag states.
// R9: status bit 3 is set when a conversion completes and the result bytes are updated.
// R10: a host read of the status byte clears the fresh-result flag.
// R11: status bit 2 gives the supply source (1 bus powered), caught after power-up and at every bus reset.
// R12: status bit 1 is set once the address was sent in arbitration and cleared only when the arbitration select is 0.
// R13: status bit 0 is set once the configuration is locked, and then configuration writes are rejected.
// R14: configuration bytes reload from the configuration memory after power-on reset, and a copy command stores them.
// R15: a status read returns the flags as they stood before clearing, and an event in the read cycle is kept.
// R16: reserved bytes read FFh and ignore writes, and status bits 5 and 4 read as ones.
package sssr_pkg;

  // ---------------------------------------------------------------
  // scratchpad byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] SSSR_OFS_RES_LO = 4'h0;
  localparam logic [3:0] SSSR_OFS_RES_HI = 4'h1;
  localparam logic [3:0] SSSR_OFS_FLAGS = 4'h2;
  localparam logic [3:0] SSSR_OFS_SPARE_A = 4'h3;
  localparam logic [3:0] SSSR_OFS_SETUP_ONE = 4'h4;
  localparam logic [3:0] SSSR_OFS_SETUP_TWO = 4'h5;
  localparam logic [3:0] SSSR_OFS_BUS_ID = 4'h6;
  localparam logic [3:0] SSSR_OFS_SPARE_B = 4'h7;
  localparam logic [3:0] SSSR_OFS_LO_LIM_L = 4'h8;
  localparam logic [3:0] SSSR_OFS_LO_LIM_H = 4'h9;
  localparam logic [3:0] SSSR_OFS_HI_LIM_L = 4'ha;
  localparam logic [3:0] SSSR_OFS_HI_LIM_H = 4'hb;
  localparam logic [3:0] SSSR_OFS_COR_L = 4'hc;
  localparam logic [3:0] SSSR_OFS_COR_H = 4'hd;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] SSSR_RST_RESULT = 16'h0000;
  localparam logic [7:0] SSSR_RST_SETUP_ONE = 8'h70;
  localparam logic [7:0] SSSR_RST_SETUP_TWO = 8'h80;
  localparam logic [7:0] SSSR_RST_BUS_ID = 8'h00;
  localparam logic [15:0] SSSR_RST_LO_LIM = 16'h0000;
  localparam logic [15:0] SSSR_RST_HI_LIM = 16'h07f0;
  localparam logic [15:0] SSSR_RST_COR = 16'h0000;
  localparam logic [7:0] SSSR_RST_PIN_SNAP = 8'hf0;
  localparam logic [7:0] SSSR_RST_PIN_SETUP = 8'h00;
  localparam logic [7:0] SSSR_SPARE_VALUE = 8'hff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SSSR_FLAG_HIGH = 7;
  localparam int SSSR_FLAG_LOW = 6;
  localparam logic [1:0] SSSR_FLAG_SPARE_BITS = 2'b11;
  localparam int SSSR_FLAG_FRESH = 3;
  localparam int SSSR_FLAG_POWER = 2;
  localparam int SSSR_FLAG_DISC = 1;
  localparam int SSSR_FLAG_LOCK = 0;
  localparam int SSSR_ONE_COMPARATOR = 4;
  localparam int SSSR_TWO_ARB_LSB = 2;
  localparam int SSSR_TWO_ARB_MSB = 3;
  localparam int SSSR_PIN_ALERT_FN = 2;
  localparam logic [3:0] SSSR_PIN_UPPER_ONES = 4'hf;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sssr_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sssr_rsp_s;

  typedef struct packed {
    logic [7:0] setup_one;
    logic [7:0] setup_two;
    logic [7:0] bus_id;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    logic [15:0] cor;
  } sssr_cfg_s;

  typedef enum logic [0:0] {
    SSSR_BOOT = 1'b0,
    SSSR_RUN = 1'b1
  } sssr_phase_e;

endpackage

// ### sssr_regs.sv
`timescale 1ns/1ps
module sssr_regs
  import sssr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // scratchpad access from the command engine
  input wire sssr_req_s req,
  output sssr_rsp_s rsp,
  // conversion engine
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  output sssr_cfg_s cfg,
  // bus events
  input wire logic bus_reset,
  input wire logic disc_addr_sent,
  input wire logic cfg_lock_set,
  input wire logic copy_req,
  // configuration memory
  input wire sssr_cfg_s ee_image,
  output logic ee_store,
  output sssr_cfg_s ee_store_image,
  // pins
  input wire logic supply_bus_powered,
  input wire logic [3:0] pin_levels,
  input wire logic pin_sample,
  input wire logic pin_setup_wr,
  input wire logic [7:0] pin_setup_data,
  output logic [7:0] pin_level_snapshot,
  output logic second_general_pin_o,
  output logic second_general_pin_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sssr_phase_e phase_q;
  logic [15:0] result_q;
  logic [7:0] setup_one_q;
  logic [7:0] setup_two_q;
  logic [7:0] bus_id_q;
  logic [15:0] lo_lim_q;
  logic [15:0] hi_lim_q;
  logic [15:0] cor_q;
  logic high_q;
  logic low_q;
  logic fresh_q;
  logic power_q;
  logic disc_q;
  logic lock_q;
  logic [7:0] pin_setup_q;
  logic [3:0] pins_sync;
  logic supply_sync;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sssr_sync #(.W(4)) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d(pin_levels),
    .q(pins_sync)
  );

  sssr_sync #(.W(1)) u_supply_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d(supply_bus_powered),
    .q(supply_sync)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic flags_read = req.rd && (req.addr == SSSR_OFS_FLAGS);
  wire logic booting = (phase_q == SSSR_BOOT);
  // locked configuration turns every configuration write away
  wire logic wr_ok = req.wr && !lock_q && !booting; // [R13]
  wire logic wr_one = wr_ok && (req.addr == SSSR_OFS_SETUP_ONE);
  wire logic wr_two = wr_ok && (req.addr == SSSR_OFS_SETUP_TWO);
  wire logic wr_id = wr_ok && (req.addr == SSSR_OFS_BUS_ID);
  wire logic wr_lo_l = wr_ok && (req.addr == SSSR_OFS_LO_LIM_L);
  wire logic wr_lo_h = wr_ok && (req.addr == SSSR_OFS_LO_LIM_H);
  wire logic wr_hi_l = wr_ok && (req.addr == SSSR_OFS_HI_LIM_L);
  wire logic wr_hi_h = wr_ok && (req.addr == SSSR_OFS_HI_LIM_H);
  wire logic wr_cor_l = wr_ok && (req.addr == SSSR_OFS_COR_L);
  wire logic wr_cor_h = wr_ok && (req.addr == SSSR_OFS_COR_H);
  wire logic comparator = setup_one_q[SSSR_ONE_COMPARATOR];
  wire logic arb_on = |setup_two_q[SSSR_TWO_ARB_MSB:SSSR_TWO_ARB_LSB];

  // ---------------------------------------------------------------
  // alert comparison on the incoming result, signed
  // ---------------------------------------------------------------
  wire logic at_high = $signed(conv_result) >= $signed(hi_lim_q); // [R6]
  wire logic at_low = $signed(conv_result) <= $signed(lo_lim_q); // [R7]
  // a read clears, but a result in the same cycle wins over the clear
  wire logic high_kept = high_q && !flags_read && !comparator; // [R4] [R5]
  wire logic low_kept = low_q && !flags_read && !comparator; // [R4] [R5]
  wire logic high_d = conv_done ? (at_high || high_kept) : (high_q && !flags_read); // [R3] [R15]
  wire logic low_d = conv_done ? (at_low || low_kept) : (low_q && !flags_read); // [R3] [R15]
  wire logic fresh_d = conv_done || (fresh_q && !flags_read); // [R9] [R10] [R15]
  wire logic disc_d = arb_on && (disc_q || disc_addr_sent); // [R12]

  // status byte as it stands before any clear of this cycle
  wire logic [7:0] flags_byte = {high_q, low_q, SSSR_FLAG_SPARE_BITS, fresh_q, power_q, disc_q, lock_q}; // [R16]

  // read mux; unused offsets read as spare
  logic [7:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      SSSR_OFS_RES_LO: rd_mux = result_q[7:0]; // [R1]
      SSSR_OFS_RES_HI: rd_mux = result_q[15:8]; // [R1]
      SSSR_OFS_FLAGS: rd_mux = flags_byte; // [R15]
      SSSR_OFS_SETUP_ONE: rd_mux = setup_one_q;
      SSSR_OFS_SETUP_TWO: rd_mux = setup_two_q;
      SSSR_OFS_BUS_ID: rd_mux = bus_id_q;
      SSSR_OFS_LO_LIM_L: rd_mux = lo_lim_q[7:0];
      SSSR_OFS_LO_LIM_H: rd_mux = lo_lim_q[15:8];
      SSSR_OFS_HI_LIM_L: rd_mux = hi_lim_q[7:0];
      SSSR_OFS_HI_LIM_H: rd_mux = hi_lim_q[15:8];
      SSSR_OFS_COR_L: rd_mux = cor_q[7:0];
      SSSR_OFS_COR_H: rd_mux = cor_q[15:8];
      default: rd_mux = SSSR_SPARE_VALUE; // [R16]
    endcase
  end

  // ---------------------------------------------------------------
  // boot phase: one cycle after reset loads the stored configuration
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      phase_q <= SSSR_BOOT;
    else
    begin
      case (phase_q)
        SSSR_BOOT: phase_q <= SSSR_RUN;
        SSSR_RUN: phase_q <= SSSR_RUN;
        default: phase_q <= SSSR_BOOT;
      endcase
    end
  end

  // configuration bytes; reload from memory during boot
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      setup_one_q <= SSSR_RST_SETUP_ONE;
      setup_two_q <= SSSR_RST_SETUP_TWO;
      bus_id_q <= SSSR_RST_BUS_ID;
      lo_lim_q <= SSSR_RST_LO_LIM;
      hi_lim_q <= SSSR_RST_HI_LIM;
      cor_q <= SSSR_RST_COR;
    end
    else if (booting)
    begin
      setup_one_q <= ee_image.setup_one; // [R14]
      setup_two_q <= ee_image.setup_two; // [R14]
      bus_id_q <= ee_image.bus_id;
      lo_lim_q <= ee_image.lo_lim;
      hi_lim_q <= ee_image.hi_lim;
      cor_q <= ee_image.cor;
    end
    else
    begin
      if (wr_one) setup_one_q <= req.wdata;
      if (wr_two) setup_two_q <= req.wdata;
      if (wr_id) bus_id_q <= req.wdata;
      if (wr_lo_l) lo_lim_q[7:0] <= req.wdata;
      if (wr_lo_h) lo_lim_q[15:8] <= req.wdata;
      if (wr_hi_l) hi_lim_q[7:0] <= req.wdata;
      if (wr_hi_h) hi_lim_q[15:8] <= req.wdata;
      if (wr_cor_l) cor_q[7:0] <= req.wdata;
      if (wr_cor_h) cor_q[15:8] <= req.wdata;
    end
  end

  // result and status flags
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      result_q <= SSSR_RST_RESULT; // [R2]
      high_q <= 1'b0;
      low_q <= 1'b0;
      fresh_q <= 1'b0;
      disc_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      if (conv_done) result_q <= conv_result; // [R1]
      high_q <= high_d;
      low_q <= low_d;
      fresh_q <= fresh_d;
      disc_q <= disc_d;
      lock_q <= lock_q || cfg_lock_set; // [R13]
    end
  end

  // supply source caught at boot and at each bus reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      power_q <= 1'b0;
    else if (booting || bus_reset)
      power_q <= supply_sync; // [R11]
  end

  // read answer one cycle after the request
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rsp <= '0;
    else
    begin
      rsp.valid <= req.rd;
      rsp.data <= req.rd ? rd_mux : rsp.data;
    end
  end

  // copy to configuration memory; a one-cycle strobe with a frozen image
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ee_store <= 1'b0;
      ee_store_image <= '0;
    end
    else
    begin
      ee_store <= copy_req && !booting; // [R14]
      if (copy_req && !booting) ee_store_image <= cfg;
    end
  end

  // pin setup, snapshot and the open-drain alert drive (pin pulled low while alerting)
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_setup_q <= SSSR_RST_PIN_SETUP;
      pin_level_snapshot <= SSSR_RST_PIN_SNAP;
      second_general_pin_oe <= 1'b0;
    end
    else
    begin
      if (pin_setup_wr) pin_setup_q <= pin_setup_data;
      if (pin_sample) pin_level_snapshot <= {SSSR_PIN_UPPER_ONES, pins_sync};
      second_general_pin_oe <= pin_setup_q[SSSR_PIN_ALERT_FN] && (high_q || low_q); // [R8]
    end
  end

  // open-drain: only ever drives low
  assign second_general_pin_o = 1'b0;
  // configuration bytes face the conversion engine straight from their flops
  assign cfg = '{setup_one: setup_one_q, setup_two: setup_two_q, bus_id: bus_id_q,
                 lo_lim: lo_lim_q, hi_lim: hi_lim_q, cor: cor_q};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_result_hold;
    @(posedge sys_clk) disable iff (reset)
    conv_done |=> (result_q == $past(conv_result)) ##1 (result_q == $past(conv_result, 2) || $past(conv_done));
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result bytes not loaded"); // [R1]

  property p_result_zero;
    @(posedge sys_clk) disable iff (reset)
    $past(reset) |-> (result_q == SSSR_RST_RESULT);
  endproperty
  a_result_zero: assert property (p_result_zero) else $error("result not zero after reset"); // [R2]

  property p_high_cmp;
    @(posedge sys_clk) disable iff (reset)
    conv_done && comparator && !wr_hi_l && !wr_hi_h |=> high_q == ($signed(result_q) >= $signed(hi_lim_q));
  endproperty
  a_high_cmp: assert property (p_high_cmp) else $error("upper flag wrong after result"); // [R6]

  property p_low_cmp;
    @(posedge sys_clk) disable iff (reset)
    conv_done && comparator && !wr_lo_l && !wr_lo_h |=> low_q == ($signed(result_q) <= $signed(lo_lim_q));
  endproperty
  a_low_cmp: assert property (p_low_cmp) else $error("lower flag wrong after result"); // [R7]

  property p_latched;
    @(posedge sys_clk) disable iff (reset)
    high_q && !comparator && !flags_read |=> high_q;
  endproperty
  a_latched: assert property (p_latched) else $error("latched upper flag dropped"); // [R5]

  property p_read_clear;
    @(posedge sys_clk) disable iff (reset)
    flags_read && !conv_done |=> !high_q && !low_q && !fresh_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear"); // [R4]

  property p_read_sample;
    @(posedge sys_clk) disable iff (reset)
    flags_read |=> rsp.valid && (rsp.data == $past(flags_byte)) && (rsp.data[5:4] == SSSR_FLAG_SPARE_BITS);
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("status answer not pre-clear value"); // [R15]

  property p_fresh_set;
    @(posedge sys_clk) disable iff (reset)
    conv_done |=> fresh_q;
  endproperty
  a_fresh_set: assert property (p_fresh_set) else $error("fresh flag not set"); // [R9]

  property p_disc_clear;
    @(posedge sys_clk) disable iff (reset)
    !arb_on |=> !disc_q;
  endproperty
  a_disc_clear: assert property (p_disc_clear) else $error("discovery flag kept with select off"); // [R12]

  property p_lock_reject;
    @(posedge sys_clk) disable iff (reset)
    lock_q && req.wr |=> $stable(setup_one_q) && $stable(hi_lim_q) && $stable(lo_lim_q);
  endproperty
  a_lock_reject: assert property (p_lock_reject) else $error("write passed while locked"); // [R13]

  property p_spare;
    @(posedge sys_clk) disable iff (reset)
    req.rd && (req.addr == SSSR_OFS_SPARE_A || req.addr == SSSR_OFS_SPARE_B) |=> rsp.data == SSSR_SPARE_VALUE;
  endproperty
  a_spare: assert property (p_spare) else $error("spare byte not FFh"); // [R16]

  property p_pin_alert;
    @(posedge sys_clk) disable iff (reset)
    pin_setup_q[SSSR_PIN_ALERT_FN] && (high_q || low_q) |=> second_general_pin_oe;
  endproperty
  a_pin_alert: assert property (p_pin_alert) else $error("alert not shown on pin"); // [R8]

  property p_boot_load;
    @(posedge sys_clk) disable iff (reset)
    booting |=> (setup_one_q == $past(ee_image.setup_one)) && (phase_q == SSSR_RUN);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("configuration not reloaded"); // [R14]

  property p_power;
    @(posedge sys_clk) disable iff (reset)
    bus_reset |=> power_q == $past(supply_sync);
  endproperty
  a_power: assert property (p_power) else $error("supply source not refreshed"); // [R11]

  property p_cov_clash;
    @(posedge sys_clk) disable iff (reset)
    flags_read && conv_done;
  endproperty
  c_cov_clash: cover property (p_cov_clash);

  property p_cov_latch;
    @(posedge sys_clk) disable iff (reset)
    high_q && !comparator ##1 flags_read;
  endproperty
  c_cov_latch: cover property (p_cov_latch);

  property p_cov_copy;
    @(posedge sys_clk) disable iff (reset)
    lock_q ##1 ee_store;
  endproperty
  c_cov_copy: cover property (p_cov_copy);

endmodule

// ### sssr_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for levels arriving from pins
module sssr_sync
  import sssr_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage; no reset here, so the pin level is
  // already settled when the boot cycle samples it right after reset
  always_ff @(posedge sys_clk)
  begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule
